// *** pkg/mshc_pkg.sv ***
// constants for the station address, group hash and phy management register bank
// ****************************************************************
// ****************************************************************
package mshc_pkg;
	localparam int mshc_addr_w = 4;
	localparam logic [3:0] mshc_off_addr_high = 4'h2;
	localparam logic [3:0] mshc_off_addr_low = 4'h3;
	localparam logic [3:0] mshc_off_hash_high = 4'h4;
	localparam logic [3:0] mshc_off_hash_low = 4'h5;
	localparam logic [3:0] mshc_off_phy_access = 4'h6;
	localparam logic [3:0] mshc_off_phy_data = 4'h7;
	localparam logic [3:0] mshc_off_filter_ctrl = 4'h8;
	localparam logic [31:0] mshc_rst_addr_high = 32'h0000ffff;
	localparam logic [31:0] mshc_rst_addr_low = 32'h0fffffff;
	localparam logic [31:0] mshc_rst_hash = 32'h00000000;
	localparam logic [31:0] mshc_rst_access = 32'h00000000;
	localparam logic [15:0] mshc_rst_data = 16'h0000;
	localparam int mshc_acc_busy_bit = 0;
	localparam int mshc_acc_dir_bit = 1;
	localparam int mshc_acc_reg_lsb = 6;
	localparam int mshc_acc_phy_lsb = 11;
	localparam int mshc_flt_pass_group_bit = 0;
	localparam logic [4:0] mshc_internal_phy = 5'h01;
	localparam logic [2:0] mshc_ee_byte_first = 3'h1;
	localparam logic [2:0] mshc_ee_byte_last = 3'h6;
	localparam int mshc_clk_mhz = 200;
	localparam int mshc_mdc_khz = 2500;
	localparam int mshc_mdc_half_cycles = (mshc_clk_mhz * 1000) / (mshc_mdc_khz * 2);
	localparam int mshc_frame_bits = 32'h40;
	localparam logic [5:0] mshc_turn_bit = 6'h2e;
	localparam logic [5:0] mshc_data_bit = 6'h30;
endpackage

// *** logic/mshc_mdio_engine.sv ***
// clause 22 management frame engine with divided mdc
`timescale 1ns/10ps
`default_nettype none
module mshc_mdio_engine
	import mshc_pkg::*;
#(
	parameter int half_cycles = mshc_mdc_half_cycles
)
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// request
	input wire logic start_in,
	input wire logic write_in,
	input wire logic [4:0] phy_in,
	input wire logic [4:0] reg_in,
	input wire logic [15:0] wdata_in,
	output logic done_out,
	output logic [15:0] rdata_out,
	// pins
	output logic mdc_out,
	output logic mdio_o_out,
	output logic mdio_oe_out,
	input wire logic mdio_in
);
	import mshc_pkg::*;
	logic [15:0] div_cnt;
	logic tick;
	logic run;
	logic [5:0] bit_idx;
	logic [63:0] shreg;
	logic mdio_s1, mdio_s2;
	logic [15:0] rd_sh;
	logic write_q;

	// ****************************************************************
	// mdc divider: one enable per half period
	// ****************************************************************
	assign tick = (div_cnt == 16'(half_cycles - 1));
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in || !run || tick)
			div_cnt <= 16'h0000;
		else
			div_cnt <= div_cnt + 16'h0001;
	end

	always_ff @(posedge core_clk_in)
	begin
		mdio_s1 <= mdio_in;
		mdio_s2 <= mdio_s1;
	end

	// ****************************************************************
	// frame shifter: 32 preamble, st, op, phy, reg, ta, data
	// ****************************************************************
	always_ff @(posedge core_clk_in)
	begin
		done_out <= 1'b0;
		if (sys_rst_in)
		begin
			run <= 1'b0;
			mdc_out <= 1'b0;
			bit_idx <= 6'h00;
			shreg <= 64'h0;
			mdio_o_out <= 1'b1;
			mdio_oe_out <= 1'b0;
			rd_sh <= 16'h0000;
			rdata_out <= 16'h0000;
			write_q <= 1'b0;
		end
		else if (!run)
		begin
			if (start_in)
			begin
				run <= 1'b1;
				write_q <= write_in;
				bit_idx <= 6'h00;
				shreg <= {32'hffffffff, 2'b01, write_in ? 2'b01 : 2'b10, phy_in, reg_in,
					2'b10, wdata_in};
				mdio_oe_out <= 1'b1;
				mdio_o_out <= 1'b1;
			end
		end
		else if (tick)
		begin
			mdc_out <= ~mdc_out;
			if (mdc_out)
			begin
				// falling edge: present the next bit
				if (bit_idx == 6'(mshc_frame_bits - 1))
				begin
					run <= 1'b0;
					mdio_oe_out <= 1'b0;
					done_out <= 1'b1;
					if (!write_q)
						rdata_out <= rd_sh;
				end
				else
				begin
					bit_idx <= bit_idx + 6'h01;
					shreg <= {shreg[62:0], 1'b0};
					mdio_o_out <= shreg[62];
					// reads release the line from turnaround on
					mdio_oe_out <= write_q || (bit_idx + 6'h01 < mshc_turn_bit);
				end
			end
			else if (!write_q && bit_idx >= mshc_data_bit)
				rd_sh <= {rd_sh[14:0], mdio_s2};
		end
		else if (bit_idx == 6'h00 && !mdc_out && div_cnt == 16'h0000)
			mdio_o_out <= shreg[63];
	end
endmodule
`default_nettype wire

// *** logic/mshc_csr.sv ***
// station address, group hash table and phy management register bank
`timescale 1ns/10ps
`default_nettype none
module mshc_csr
	import mshc_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// register port
	input wire logic [mshc_pkg::mshc_addr_w-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// eeprom power-on load
	input wire logic ee_valid_in,
	input wire logic [2:0] ee_byte_addr_in,
	input wire logic [7:0] ee_byte_in,
	// receive address filter
	input wire logic rx_check_in,
	input wire logic [47:0] rx_dest_in,
	input wire logic [5:0] rx_hash_in,
	output logic rx_accept_out,
	output logic rx_check_done_out,
	// management pins
	output logic mdc_out,
	output logic mdio_o_out,
	output logic mdio_oe_out,
	input wire logic mdio_in,
	output logic internal_phy_sel_out
);
	import mshc_pkg::*;
	logic [15:0] addr_high;
	logic [31:0] addr_low;
	logic [31:0] hash_high;
	logic [31:0] hash_low;
	logic [4:0] acc_phy;
	logic [4:0] acc_reg;
	logic acc_dir;
	logic acc_busy;
	logic [15:0] phy_data;
	logic pass_group;
	logic start;
	logic eng_done;
	logic [15:0] eng_rdata;
	logic eng_mdc, eng_mdio_o, eng_mdio_oe;
	logic wr_acc;
	logic [63:0] hash_all;
	logic [47:0] station;
	logic hit_bit;
	logic is_group;

	// ****************************************************************
	// station address with power-on eeprom load
	// ****************************************************************
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			addr_high <= mshc_rst_addr_high[15:0];
			addr_low <= mshc_rst_addr_low;
		end
		else if (ee_valid_in && ee_byte_addr_in >= mshc_ee_byte_first
			&& ee_byte_addr_in <= mshc_ee_byte_last)
		begin
			unique case (ee_byte_addr_in)
				3'h1: addr_low[7:0] <= ee_byte_in;
				3'h2: addr_low[15:8] <= ee_byte_in;
				3'h3: addr_low[23:16] <= ee_byte_in;
				3'h4: addr_low[31:24] <= ee_byte_in;
				3'h5: addr_high[7:0] <= ee_byte_in;
				3'h6: addr_high[15:8] <= ee_byte_in;
				default: addr_high <= addr_high;
			endcase
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == mshc_off_addr_high)
				addr_high <= reg_wdata_in[15:0];
			if (reg_addr_in == mshc_off_addr_low)
				addr_low <= reg_wdata_in;
		end
	end

	// ****************************************************************
	// group hash table and filter control
	// ****************************************************************
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			hash_high <= mshc_rst_hash;
			hash_low <= mshc_rst_hash;
			pass_group <= 1'b0;
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == mshc_off_hash_high)
				hash_high <= reg_wdata_in;
			if (reg_addr_in == mshc_off_hash_low)
				hash_low <= reg_wdata_in;
			if (reg_addr_in == mshc_off_filter_ctrl)
				pass_group <= reg_wdata_in[mshc_flt_pass_group_bit];
		end
	end

	// ****************************************************************
	// receive filter: unicast exact match, group by hash
	// ****************************************************************
	assign hash_all = {hash_high, hash_low};
	assign hit_bit = hash_all[rx_hash_in];
	// destination octet one sits in the low byte of the low register
	assign station = {addr_high, addr_low};
	assign is_group = rx_dest_in[0];
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			rx_accept_out <= 1'b0;
			rx_check_done_out <= 1'b0;
		end
		else
		begin
			rx_check_done_out <= rx_check_in;
			if (rx_check_in)
			begin
				if (is_group)
					rx_accept_out <= pass_group || hit_bit;
				else
					rx_accept_out <= (rx_dest_in == station);
			end
		end
	end

	// ****************************************************************
	// management access and data registers
	// ****************************************************************
	// a write while busy is dropped so a running frame is never corrupted
	assign wr_acc = reg_wr_in && reg_addr_in == mshc_off_phy_access && !acc_busy;
	assign start = wr_acc && reg_wdata_in[mshc_acc_busy_bit];
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			acc_phy <= mshc_rst_access[mshc_acc_phy_lsb +: 5];
			acc_reg <= mshc_rst_access[mshc_acc_reg_lsb +: 5];
			acc_dir <= mshc_rst_access[mshc_acc_dir_bit];
			acc_busy <= mshc_rst_access[mshc_acc_busy_bit];
		end
		else if (wr_acc)
		begin
			acc_phy <= reg_wdata_in[mshc_acc_phy_lsb +: 5];
			acc_reg <= reg_wdata_in[mshc_acc_reg_lsb +: 5];
			acc_dir <= reg_wdata_in[mshc_acc_dir_bit];
			acc_busy <= reg_wdata_in[mshc_acc_busy_bit];
		end
		else if (eng_done)
			acc_busy <= 1'b0;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			phy_data <= mshc_rst_data;
		else if (eng_done && !acc_dir)
			phy_data <= eng_rdata;
		else if (reg_wr_in && reg_addr_in == mshc_off_phy_data && !acc_busy)
			phy_data <= reg_wdata_in[15:0];
	end

	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			internal_phy_sel_out <= 1'b0;
		else
			internal_phy_sel_out <= acc_busy && (acc_phy == mshc_internal_phy);
	end

	mshc_mdio_engine u_engine (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.start_in(start),
		.write_in(reg_wdata_in[mshc_acc_dir_bit]),
		.phy_in(reg_wdata_in[mshc_acc_phy_lsb +: 5]),
		.reg_in(reg_wdata_in[mshc_acc_reg_lsb +: 5]),
		.wdata_in(phy_data),
		.done_out(eng_done),
		.rdata_out(eng_rdata),
		.mdc_out(eng_mdc),
		.mdio_o_out(eng_mdio_o),
		.mdio_oe_out(eng_mdio_oe),
		.mdio_in(mdio_in)
	);

	// outputs registered once more so they come straight from flops
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			mdc_out <= 1'b0;
			mdio_o_out <= 1'b1;
			mdio_oe_out <= 1'b0;
		end
		else
		begin
			mdc_out <= eng_mdc;
			mdio_o_out <= eng_mdio_o;
			mdio_oe_out <= eng_mdio_oe;
		end
	end

	// ****************************************************************
	// read port, data one cycle after the strobe
	// ****************************************************************
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
			reg_rdata_out <= 32'h00000000;
		else if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				mshc_off_addr_high: reg_rdata_out <= {16'h0000, addr_high};
				mshc_off_addr_low: reg_rdata_out <= addr_low;
				mshc_off_hash_high: reg_rdata_out <= hash_high;
				mshc_off_hash_low: reg_rdata_out <= hash_low;
				mshc_off_phy_access: reg_rdata_out <= {16'h0000, acc_phy, acc_reg, 4'h0,
					acc_dir, acc_busy};
				mshc_off_phy_data: reg_rdata_out <= {16'h0000, phy_data};
				mshc_off_filter_ctrl: reg_rdata_out <= {31'h0, pass_group};
				default: reg_rdata_out <= 32'h00000000;
			endcase
		end
		else
			reg_rdata_out <= 32'h00000000;
	end
endmodule
`default_nettype wire

// *** tb/mshc_csr_props.sv ***
// port assertions for the register bank
`timescale 1ns/10ps
`default_nettype none
module mshc_csr_props
	import mshc_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	// register port
	input wire logic [mshc_pkg::mshc_addr_w-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	// filter
	input wire logic rx_check_in,
	input wire logic [47:0] rx_dest_in,
	input wire logic [5:0] rx_hash_in,
	input wire logic rx_accept_out,
	input wire logic rx_check_done_out,
	// management
	input wire logic mdc_out,
	input wire logic mdio_o_out,
	input wire logic mdio_oe_out,
	input wire logic internal_phy_sel_out
);
	// ****
	// shadow filter state and properties
	// ****
	logic [63:0] hash_sh;
	logic pass_sh;
	logic hbit;
	logic go_int;
	assign hbit = hash_sh[rx_hash_in];
	assign go_int = reg_wr_in && reg_addr_in == mshc_off_phy_access && reg_wdata_in[0]
		&& reg_wdata_in[15:11] == mshc_internal_phy;
	always_ff @(posedge core_clk_in)
	begin
		if (sys_rst_in)
		begin
			hash_sh <= 64'h0;
			pass_sh <= 1'b0;
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == mshc_off_hash_high) hash_sh[63:32] <= reg_wdata_in;
			if (reg_addr_in == mshc_off_hash_low) hash_sh[31:0] <= reg_wdata_in;
			if (reg_addr_in == mshc_off_filter_ctrl) pass_sh <= reg_wdata_in[0];
		end
	end
	default clocking
		@(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence start_s;
		reg_wr_in && reg_addr_in == mshc_off_phy_access && reg_wdata_in[0];
	endsequence
	sequence start_int_s;
		go_int;
	endsequence
	sequence grp_s;
		rx_check_in && rx_dest_in[0];
	endsequence
	reset_out_a: assert property ($fell(sys_rst_in) |-> !mdio_oe_out && mdio_o_out && !rx_accept_out)
		else $error("outputs not at reset level");
	rd_slot_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data outside its slot");
	high_resv_a: assert property (reg_rd_in && reg_addr_in == mshc_off_addr_high |=> reg_rdata_out[31:16] == 16'h0)
		else $error("address high upper bits set");
	pass_all_a: assert property (grp_s ##0 pass_sh |=> rx_check_done_out && rx_accept_out)
		else $error("group frame refused in pass all");
	hash_pick_a: assert property (grp_s ##0 !pass_sh |=> rx_accept_out == $past(hbit))
		else $error("group accept differs from table bit");
	mdc_run_a: assert property (start_s |-> ##[1:200] $rose(mdc_out))
		else $error("no mdc after start");
	sel_rise_a: assert property ($rose(internal_phy_sel_out) |-> $past(go_int) || $past(go_int, 2))
		else $error("internal phy select without start");
	sel_hold_a: assert property (start_int_s |=> ##1 internal_phy_sel_out [*8])
		else $error("internal phy select dropped early");
	done_pulse_a: assert property (rx_check_in |=> rx_check_done_out ##1 !rx_check_done_out)
		else $error("check done not one pulse");
endmodule
bind mshc_csr mshc_csr_props u_props (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .rx_check_in(rx_check_in),
	.rx_dest_in(rx_dest_in), .rx_hash_in(rx_hash_in), .rx_accept_out(rx_accept_out),
	.rx_check_done_out(rx_check_done_out), .mdc_out(mdc_out), .mdio_o_out(mdio_o_out),
	.mdio_oe_out(mdio_oe_out), .internal_phy_sel_out(internal_phy_sel_out));
`default_nettype wire

// *** tb/mshc_phy_model.sv ***
// management port model of the phy with a fixed read value
`timescale 1ns/10ps
`default_nettype none
module mshc_phy_model
(
	// pins
	input wire logic mdc_in,
	input wire logic mdio_o_in,
	input wire logic mdio_oe_in,
	output logic mdio_out,
	// last frame seen on the wire
	output logic [63:0] frame_out
);
	// ****
	// frame tracking
	// ****
	logic [5:0] cnt = 6'h00;
	logic [15:0] rd_val = 16'h3c5a;
	logic drv = 1'b0;
	logic bit_v = 1'b1;
	always @(posedge mdc_in)
	begin
		frame_out <= {frame_out[62:0], mdio_out};
		cnt <= cnt + 6'h01;
	end
	// drive after the master releases: turnaround zero, then data msb first
	always @(negedge mdc_in)
	begin
		drv <= !mdio_oe_in && cnt >= 6'h2f;
		bit_v <= (cnt == 6'h2f) ? 1'b0 : rd_val[~cnt[3:0]];
	end
	// a released line floats up through the pull-up
	assign mdio_out = mdio_oe_in ? mdio_o_in : ((drv && cnt != 6'h00) ? bit_v : 1'b1);
endmodule
`default_nettype wire

// *** tb/mshc_csr_test.sv ***
// self-checking bench for the register bank
`timescale 1ns/10ps
`default_nettype none
module mshc_csr_test;
	import mshc_pkg::*;
	// ****
	// stimulus and checking
	// ****
	logic core_clk_in = 1'b0, sys_rst_in = 1'b1, rd_d = 1'b0;
	logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, ee_valid_in = 1'b0, rx_check_in = 1'b0;
	logic [3:0] reg_addr_in = 4'h0;
	logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, v, hh, hl;
	logic [31:0] seed = 32'h61d5e9c9;
	logic [2:0] ee_byte_addr_in = 3'h0;
	logic [7:0] ee_byte_in = 8'h0;
	logic [47:0] rx_dest_in = 48'h0, mac = 48'hbc9a78563412;
	logic [5:0] rx_hash_in = 6'h0, ix;
	logic [63:0] frame, ht;
	logic [32:0] pe;
	logic rx_accept_out, rx_check_done_out, mdc_out, mdio_o_out, mdio_oe_out, mdio_in, sel;
	logic [32:0] rq[$];
	logic aq[$];
	int mismatches = 0, n_tests = 0;
	mshc_csr uut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .ee_valid_in(ee_valid_in), .ee_byte_addr_in(ee_byte_addr_in),
		.ee_byte_in(ee_byte_in), .rx_check_in(rx_check_in), .rx_dest_in(rx_dest_in),
		.rx_hash_in(rx_hash_in), .rx_accept_out(rx_accept_out), .rx_check_done_out(rx_check_done_out),
		.mdc_out(mdc_out), .mdio_o_out(mdio_o_out), .mdio_oe_out(mdio_oe_out), .mdio_in(mdio_in),
		.internal_phy_sel_out(sel));
	mshc_phy_model phy (.mdc_in(mdc_out), .mdio_o_in(mdio_o_out), .mdio_oe_in(mdio_oe_out),
		.mdio_out(mdio_in), .frame_out(frame));
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task cmp(input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %0t exp %h got %h", $time, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge core_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	// a note without its flag only keeps the queue in step with polling reads
	task rd(input logic [3:0] a, input logic [31:0] e, input logic note);
		@(posedge core_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		rq.push_back({note, e});
		@(posedge core_clk_in);
		reg_rd_in <= 1'b0;
		#1 v = reg_rdata_out;
	endtask
	task chk(input logic [47:0] d, input logic [5:0] h, input logic e);
		@(posedge core_clk_in);
		rx_check_in <= 1'b1;
		rx_dest_in <= d;
		rx_hash_in <= h;
		aq.push_back(e);
		@(posedge core_clk_in);
		rx_check_in <= 1'b0;
	endtask
	task idle();
		int n;
		n = 0;
		v = 32'h1;
		while (v[0] !== 1'b0 && n < 8000)
		begin
			rd(mshc_off_phy_access, 32'h0, 1'b0);
			n++;
		end
		if (n == 8000) mismatches++;
	endtask
	task summarize();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge core_clk_in)
	begin
		rd_d <= reg_rd_in;
		if (rd_d) pe = rq.pop_front();
		if (rd_d && pe[32]) cmp(pe[31:0], reg_rdata_out);
		if (rx_check_done_out) cmp(aq.pop_front(), rx_accept_out);
	end
	initial
	begin
		forever #2.5 core_clk_in = ~core_clk_in;
	end
	initial
	begin
		#300000;
		mismatches++;
		summarize();
	end
	initial
	begin
		repeat (2) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		rd(4'h2, 32'h0000ffff, 1'b1);
		rd(4'h3, 32'h0fffffff, 1'b1);
		for (int i = 4; i < 7; i++) rd(4'(i), 32'h0, 1'b1);
		rd(4'hf, 32'h0, 1'b1);
		for (int i = 1; i < 7; i++)
		begin
			@(posedge core_clk_in);
			ee_valid_in <= 1'b1;
			ee_byte_addr_in <= 3'(i);
			ee_byte_in <= mac[8*(i-1)+:8];
		end
		@(posedge core_clk_in);
		ee_valid_in <= 1'b0;
		rd(4'h3, mac[31:0], 1'b1);
		rd(4'h2, {16'h0, mac[47:32]}, 1'b1);
		chk(mac, 6'h0, 1'b1);
		chk(mac ^ 48'h100, 6'h0, 1'b0);
		wr(4'h2, 32'hffff1234);
		rd(4'h2, 32'h00001234, 1'b1);
		hh = rnd();
		hl = rnd();
		ht = {hh, hl};
		wr(4'h4, hh);
		wr(4'h5, hl);
		rd(4'h4, hh, 1'b1);
		rd(4'h5, hl, 1'b1);
		for (int k = 0; k < 12; k++)
		begin
			ix = (k == 0) ? 6'h0 : (k == 1) ? 6'h3f : 6'(rnd());
			v = rnd();
			chk({v[15:0], rnd()} | 48'h1, ix, ht[ix]);
		end
		wr(4'h5, 32'h0);
		wr(mshc_off_filter_ctrl, 32'h1);
		chk(48'h1, 6'h0, 1'b1);
		wr(mshc_off_filter_ctrl, 32'h0);
		chk(48'h1, 6'h0, 1'b0);
		wr(4'h7, 32'h0000a5c3);
		wr(4'h6, 32'h00000943);
		rd(4'h6, 32'h00000943, 1'b1);
		cmp(64'(1'b1), 64'(sel));
		wr(4'h7, 32'h00001111);
		idle();
		cmp({32'hffffffff, 4'b0101, 5'h01, 5'h05, 2'b10, 16'ha5c3}, frame);
		rd(4'h7, 32'h0000a5c3, 1'b1);
		wr(4'h6, 32'h00001881);
		rd(4'h6, 32'h00001881, 1'b1);
		cmp(64'(1'b0), 64'(sel));
		idle();
		cmp({32'hffffffff, 4'b0110, 5'h03, 5'h02, 2'b10, 16'h3c5a}, frame);
		rd(4'h7, 32'h00003c5a, 1'b1);
		repeat (4) @(posedge core_clk_in);
		summarize();
	end
endmodule
`default_nettype wire
